// [rtl/cmb_defs.svh]
/*
 cassette motion and backspace control: timing counts and thresholds.
 assumes a 20 MHz system clock.
*/
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH
`define CMB_CLK_HZ        20000000
`define CMB_BIT_NS        156250
`define CMB_CLK_NS        50
// one bit period in system clocks (156.25 us / 50 ns)
`define CMB_BIT_CYC       (`CMB_BIT_NS / `CMB_CLK_NS)
// gap declared after 21/4 bit periods of silence
`define CMB_GAP_CYC       ((21 * `CMB_BIT_CYC) / 4)
// bit dropout after 5/4 bit periods without a transition
`define CMB_DROP_CYC      ((5 * `CMB_BIT_CYC) / 4)
`define CMB_BITS_IN_BLOCK 16
`define CMB_REF_STOP      64
`define CMB_GAP_WRITE_CYC 4096
`endif

// [rtl/cmb_pkg.sv]
/*
 cassette motion and backspace control: shared types.
 assumes nothing beyond the header of constants.
*/
package cmb_pkg;
   typedef enum logic [3:0] {
      CMB_BS_IDLE  = 4'b0001,
      CMB_BS_COUNT = 4'b0010,
      CMB_BS_SEEK  = 4'b0100,
      CMB_BS_DELAY = 4'b1000
   } cmb_bs_state_t;
endpackage

// [rtl/cmb_sync.sv]
/*
 three-stage input synchroniser with agreement filter.
 assumes asynchronous inputs; output changes once stages two and three agree.
*/
module cmb_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_nxt;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
      end
   endgenerate

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= q_nxt;
      end
   end
endmodule

// [rtl/cmb_motion.sv]
/*
 cassette motion latches, command decode, ready signals, end flags and the
 block backspace controller.
 assumes transport sensors, switches and read transitions are asynchronous
 pins; latch inputs from the read/write controllers come from this clock.
*/
`include "cmb_defs.svh"

// What this block does
// - block reverse drives reverse in playback, counts bits
// - sixteen clean bits then seek gap
// - gap after 21/4 silent bit periods
// - stop after 64 reference clocks
// - rewind latch needs door, idle, not left
// - rewind gives reverse, fast until stop/left
// - load latch on leader with preconditions
// - load drives forward, write when recording
// - leader end, mark, gap written, clear
// - fast forward off leader, until right/stop
// - write is record and load/write/erase
// - forward from write, ff, load, playback read
// - reverse from rewind or playback blockrev
// - fast from ff or rewind only
// - recorder ready conditions
// - playback ready conditions
// - line position requires on-line
// - end flags by direction, right flag not in load
// - block reverse clears read error
module cmb_motion #(
   parameter int GAP_WRITE_CYC = `CMB_GAP_WRITE_CYC
) (
   // system
   input  wire logic clock,
   input  wire logic nrst,
   // panel switches
   input  wire logic rewind_switch,
   input  wire logic load_fast_fwd_switch,
   input  wire logic stop_switch,
   input  wire logic stop_switch_ext,
   input  wire logic record_off,
   input  wire logic playback_off,
   input  wire logic record_line_pos,
   input  wire logic playback_line_pos,
   input  wire logic on_line,
   // modes
   input  wire logic record_mode,
   input  wire logic playback_mode,
   // transport sensors
   input  wire logic cassette_present,
   input  wire logic door_closed,
   input  wire logic write_tab,
   input  wire logic on_clear_leader,
   input  wire logic bot_mark,
   input  wire logic end_marker,
   input  wire logic read_data_a,
   input  wire logic read_data_b,
   input  wire logic transport_ref_clock,
   // controller latches on this clock
   input  wire logic busy,
   input  wire logic tape_write_latch,
   input  wire logic tape_erase_latch,
   input  wire logic read_latch,
   input  wire logic block_reverse_cmd,
   // transport commands
   output logic      write_cmd,
   output logic      forward_cmd,
   output logic      reverse_cmd,
   output logic      fast_cmd,
   // status
   output logic      recorder_ready,
   output logic      recorder_lamp,
   output logic      playback_ready,
   output logic      playback_lamp,
   output logic      left_end_flag,
   output logic      right_end_flag,
   output logic      rewind_latch,
   output logic      load_latch,
   output logic      fast_forward_latch,
   output logic      leader_end_flag,
   output logic      gap_flag,
   output logic      block_reverse_latch,
   output logic      read_error_clear
);
   import cmb_pkg::*;

   localparam int NS = 12;
   localparam logic [15:0] GAP_CYC  = 16'(`CMB_GAP_CYC);
   localparam logic [15:0] DROP_CYC = 16'(`CMB_DROP_CYC);
   localparam logic [4:0]  BITS_BLK = 5'(`CMB_BITS_IN_BLOCK);
   localparam logic [6:0]  REF_STOP = 7'(`CMB_REF_STOP);
   localparam logic [15:0] GAP_WR   = 16'(GAP_WRITE_CYC);

   logic [NS-1:0] raw;
   logic [NS-1:0] syn;
   assign raw = {rewind_switch, load_fast_fwd_switch, stop_switch, stop_switch_ext,
                 door_closed, write_tab, on_clear_leader, bot_mark, end_marker,
                 read_data_a, read_data_b, transport_ref_clock};

   cmb_sync #(.W(NS)) u_sync (
      .clock (clock),
      .nrst  (nrst),
      .d     (raw),
      .q     (syn)
   );

   wire rew_s  = syn[11];
   wire lff_s  = syn[10];
   wire stop_s = syn[9] | syn[8];
   wire door_s = syn[7];
   wire tab_s  = syn[6];
   wire ldr_s  = syn[5];
   wire bot_s  = syn[4];
   wire end_s  = syn[3];
   wire rda_s  = syn[2];
   wire rdb_s  = syn[1];
   wire ref_s  = syn[0];

   // edge detection on filtered levels; the block reverse command is taken unfiltered
   logic rew_d_r, lff_d_r, rda_d_r, rdb_d_r, ref_d_r, bot_d_r, ldr_d_r, brev_d_r;
   wire rew_press = rew_s & ~rew_d_r;
   wire lff_press = lff_s & ~lff_d_r;
   wire bot_rise  = bot_s & ~bot_d_r;
   wire ldr_fall  = ~ldr_s & ldr_d_r;
   wire trans     = (rda_s ^ rda_d_r) | (rdb_s ^ rdb_d_r);
   wire ref_tick  = ref_s & ~ref_d_r;
   wire brev_rise = block_reverse_cmd & ~brev_d_r;

   wire moving = forward_cmd | reverse_cmd;

   // start conditions
   wire rew_ok  = door_s & ~left_end_flag & ~moving & ~busy;
   wire fwd_ok  = door_s & (tab_s | ~record_mode) & ~right_end_flag
                  & ~moving & ~busy;
   wire set_rew = rew_press & rew_ok;
   wire set_ld  = lff_press & fwd_ok & ldr_s;
   wire set_ff  = lff_press & fwd_ok & ~ldr_s;

   // backspace machine
   cmb_bs_state_t bs_r, bs_nxt;
   logic [15:0] quiet_r, quiet_nxt;
   logic [4:0]  bits_r, bits_nxt;
   logic [6:0]  refs_r, refs_nxt;
   logic        brev_nxt;
   wire dropout = quiet_r >= DROP_CYC;
   wire gap_hit = quiet_r >= GAP_CYC;

   always_comb begin
      bs_nxt    = bs_r;
      bits_nxt  = bits_r;
      refs_nxt  = refs_r;
      brev_nxt  = block_reverse_latch;
      quiet_nxt = trans ? 16'h0000 : ((quiet_r == 16'hffff) ? quiet_r : quiet_r + 16'h0001);
      unique case (bs_r)
         CMB_BS_IDLE: begin
            if (brev_rise) begin
               bs_nxt    = CMB_BS_COUNT;
               brev_nxt  = 1'b1;
               bits_nxt  = 5'h00;
               quiet_nxt = 16'h0000;
            end
         end
         CMB_BS_COUNT: begin
            if (dropout && !trans) begin
               bits_nxt = 5'h00;
            end else if (trans && bits_r < BITS_BLK) begin
               bits_nxt = bits_r + 5'h01;
            end
            if (bits_r >= BITS_BLK) begin
               bs_nxt = CMB_BS_SEEK;
            end
         end
         CMB_BS_SEEK: begin
            if (gap_hit) begin
               bs_nxt   = CMB_BS_DELAY;
               refs_nxt = 7'h00;
            end
         end
         CMB_BS_DELAY: begin
            if (ref_tick) begin
               refs_nxt = refs_r + 7'h01;
            end
            if (refs_r >= REF_STOP) begin
               bs_nxt   = CMB_BS_IDLE;
               brev_nxt = 1'b0;
            end
         end
      endcase
      if (stop_s) begin
         bs_nxt   = CMB_BS_IDLE;
         brev_nxt = 1'b0;
      end
   end

   // load sequence gap write counter
   logic [15:0] gwr_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rew_d_r  <= 1'b0;
         lff_d_r  <= 1'b0;
         rda_d_r  <= 1'b0;
         rdb_d_r  <= 1'b0;
         ref_d_r  <= 1'b0;
         bot_d_r  <= 1'b0;
         ldr_d_r  <= 1'b0;
         brev_d_r <= 1'b0;
      end else begin
         rew_d_r  <= rew_s;
         lff_d_r  <= lff_s;
         rda_d_r  <= rda_s;
         rdb_d_r  <= rdb_s;
         ref_d_r  <= ref_s;
         bot_d_r  <= bot_s;
         ldr_d_r  <= ldr_s;
         brev_d_r <= block_reverse_cmd;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bs_r                <= CMB_BS_IDLE;
         quiet_r             <= 16'h0000;
         bits_r              <= 5'h00;
         refs_r              <= 7'h00;
         block_reverse_latch <= 1'b0;
         read_error_clear    <= 1'b0;
      end else begin
         bs_r                <= bs_nxt;
         quiet_r             <= quiet_nxt;
         bits_r              <= bits_nxt;
         refs_r              <= refs_nxt;
         block_reverse_latch <= brev_nxt;
         read_error_clear    <= brev_rise;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rewind_latch       <= 1'b0;
         load_latch         <= 1'b0;
         fast_forward_latch <= 1'b0;
         leader_end_flag    <= 1'b0;
         gap_flag           <= 1'b0;
         gwr_r              <= 16'h0000;
         left_end_flag      <= 1'b0;
         right_end_flag     <= 1'b0;
      end else begin
         if (set_rew) begin
            rewind_latch <= 1'b1;
         end else if (stop_s || left_end_flag) begin
            rewind_latch <= 1'b0;
         end
         if (set_ff) begin
            fast_forward_latch <= 1'b1;
         end else if (stop_s || right_end_flag) begin
            fast_forward_latch <= 1'b0;
         end
         if (set_ld) begin
            load_latch <= 1'b1;
         end else if (load_latch) begin
            if (!leader_end_flag && ldr_fall) begin
               leader_end_flag <= 1'b1;
            end else if (leader_end_flag && !gap_flag && bot_rise) begin
               gap_flag <= 1'b1;
               gwr_r    <= GAP_WR;
            end else if (gap_flag) begin
               if (gwr_r == 16'h0000) begin
                  load_latch      <= 1'b0;
                  leader_end_flag <= 1'b0;
                  gap_flag        <= 1'b0;
               end else begin
                  gwr_r <= gwr_r - 16'h0001;
               end
            end
         end
         // end flags: sensed end marker by direction; cleared off the marker
         if (end_s && reverse_cmd) begin
            left_end_flag <= 1'b1;
         end else if (!end_s && forward_cmd) begin
            left_end_flag <= 1'b0;
         end
         if (end_s && forward_cmd && !load_latch) begin
            right_end_flag <= 1'b1;
         end else if (!end_s && reverse_cmd) begin
            right_end_flag <= 1'b0;
         end
      end
   end

   // command decode
   assign write_cmd   = record_mode & (load_latch | tape_write_latch
                        | tape_erase_latch);
   assign forward_cmd = write_cmd | fast_forward_latch | load_latch
                        | (playback_mode & read_latch);
   assign reverse_cmd = rewind_latch | (playback_mode & block_reverse_latch);
   assign fast_cmd    = fast_forward_latch | rewind_latch;

   // ready decode
   wire base_rdy = cassette_present & ~fast_cmd & ~load_latch & ~ldr_s;
   assign recorder_ready = base_rdy & record_mode & tab_s & ~record_off
                           & (~record_line_pos | on_line);
   assign playback_ready = base_rdy & playback_mode & ~playback_off
                           & (~playback_line_pos | on_line);
   assign recorder_lamp  = recorder_ready;
   assign playback_lamp  = playback_ready;

   // checks
   property p_fast_src;
      @(posedge clock) disable iff (!nrst)
      fast_cmd == (fast_forward_latch | rewind_latch);
   endproperty
   a_fast_src: assert property (p_fast_src) else $error("fast mismatch");
   property p_rev_src;
      @(posedge clock) disable iff (!nrst)
      rewind_latch |-> reverse_cmd && fast_cmd;
   endproperty
   a_rev_src: assert property (p_rev_src) else $error("rewind not reversing");
   property p_write;
      @(posedge clock) disable iff (!nrst)
      write_cmd == (record_mode & (load_latch | tape_write_latch | tape_erase_latch));
   endproperty
   a_write: assert property (p_write) else $error("write mismatch");
   property p_fwd;
      @(posedge clock) disable iff (!nrst)
      (write_cmd || fast_forward_latch || (playback_mode && read_latch)) |-> forward_cmd;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward missing");
   property p_rewind_stop;
      @(posedge clock) disable iff (!nrst)
      (rewind_latch && stop_s && !set_rew) |=> !rewind_latch;
   endproperty
   a_rewind_stop: assert property (p_rewind_stop) else $error("rewind not stopped");
   property p_ready;
      @(posedge clock) disable iff (!nrst)
      recorder_ready |-> cassette_present && !fast_cmd && record_mode && !record_off;
   endproperty
   a_ready: assert property (p_ready) else $error("recorder ready wrong");
   property p_line;
      @(posedge clock) disable iff (!nrst)
      (playback_line_pos && !on_line) |-> !playback_ready;
   endproperty
   a_line: assert property (p_line) else $error("line ready wrong");
   sequence s_seek_gap;
      bs_r == CMB_BS_SEEK && gap_hit && !stop_s;
   endsequence
   property p_gap_delay;
      @(posedge clock) disable iff (!nrst)
      s_seek_gap |=> bs_r == CMB_BS_DELAY && refs_r == 7'h00;
   endproperty
   a_gap_delay: assert property (p_gap_delay) else $error("gap not taken");
   property p_ref_stop;
      @(posedge clock) disable iff (!nrst)
      (bs_r == CMB_BS_DELAY && refs_r < REF_STOP && !stop_s) |=> block_reverse_latch;
   endproperty
   a_ref_stop: assert property (p_ref_stop) else $error("stopped early");
   property p_count16;
      @(posedge clock) disable iff (!nrst)
      (bs_r == CMB_BS_COUNT && bits_r >= BITS_BLK && !stop_s) |=> bs_r == CMB_BS_SEEK;
   endproperty
   a_count16: assert property (p_count16) else $error("no seek after 16");
   property p_err_clr;
      @(posedge clock) disable iff (!nrst)
      brev_rise |=> read_error_clear;
   endproperty
   a_err_clr: assert property (p_err_clr) else $error("error not cleared");
endmodule

// [test/cmb_xport_model.sv]
/*
 transport stand-in: write head gating, read echo, playback transitions and
 the reference clock.
 assumes motion commands arrive on the system clock.
*/
module cmb_xport_model #(
   parameter int REF_P = 100
) (
   // system
   input  wire logic clock,
   // commands and sensors
   input  wire logic write_cmd,
   input  wire logic forward_cmd,
   input  wire logic reverse_cmd,
   input  wire logic write_tab,
   input  wire logic wdata,
   // head and reference
   output logic      read_data_a,
   output logic      read_data_b,
   output logic      head_drive,
   output logic      transport_ref_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_r = 1'b0;
   int   ref_cnt = 0;
   logic writing;
   logic moving;
   assign moving = forward_cmd | reverse_cmd;
   assign writing = write_cmd & write_tab;
   assign head_drive = writing ? wdata : 1'b0;
   assign read_data_a = writing ? wdata : rd_r;
   assign read_data_b = writing ? ~wdata : ~rd_r;
   // reference stands still while the tape is stopped
   always @(posedge clock) begin
      if (moving)
         ref_cnt <= (ref_cnt + 1) % REF_P;
      else
         ref_cnt <= 0;
   end
   assign transport_ref_clock = moving && (ref_cnt >= REF_P / 2);
   // one data transition per bit period
   task automatic play_bits(input int n);
      repeat (n) begin
         repeat (3125) @(posedge clock);
         rd_r <= ~rd_r;
      end
   endtask
endmodule

// [test/cmb_tb.sv]
/*
 self-checking bench for the motion and backspace block.
 assumes the transport model and a 20 MHz clock.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int REF_P = 100;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic rew_sw = 1'b0, lff_sw = 1'b0, stp = 1'b0, stpx = 1'b0;
   logic roff = 1'b0, poff = 1'b0, rlp = 1'b0, plp = 1'b0, onl = 1'b0;
   logic rec = 1'b0, pb = 1'b0, cp = 1'b1, door = 1'b1, tab = 1'b0;
   logic ocl = 1'b0, bot = 1'b0, endm = 1'b0, busy = 1'b0, tw = 1'b0;
   logic te = 1'b0, rdl = 1'b0, brev = 1'b0, wdata = 1'b0;
   wire  rda, rdb, refc, head;
   wire  wr, fw, rv, fa, rr, rlamp, pr, plamp, le, re, rwl, ldl, ffl, lef, gpf, bsl, rec_clr;
   int   n_errors = 0;
   int   comparisons = 0;
   int   cyc_cnt = 0;
   cmb_motion #(.GAP_WRITE_CYC(8)) dut_u (
      .clock(clock), .nrst(nrst), .rewind_switch(rew_sw), .load_fast_fwd_switch(lff_sw),
      .stop_switch(stp), .stop_switch_ext(stpx), .record_off(roff), .playback_off(poff),
      .record_line_pos(rlp), .playback_line_pos(plp), .on_line(onl), .record_mode(rec),
      .playback_mode(pb), .cassette_present(cp), .door_closed(door), .write_tab(tab),
      .on_clear_leader(ocl), .bot_mark(bot), .end_marker(endm), .read_data_a(rda),
      .read_data_b(rdb), .transport_ref_clock(refc), .busy(busy), .tape_write_latch(tw),
      .tape_erase_latch(te), .read_latch(rdl), .block_reverse_cmd(brev), .write_cmd(wr),
      .forward_cmd(fw), .reverse_cmd(rv), .fast_cmd(fa), .recorder_ready(rr),
      .recorder_lamp(rlamp), .playback_ready(pr), .playback_lamp(plamp),
      .left_end_flag(le), .right_end_flag(re), .rewind_latch(rwl), .load_latch(ldl),
      .fast_forward_latch(ffl), .leader_end_flag(lef), .gap_flag(gpf),
      .block_reverse_latch(bsl), .read_error_clear(rec_clr));
   cmb_xport_model #(.REF_P(REF_P)) xp_u (
      .clock(clock), .write_cmd(wr), .forward_cmd(fw), .reverse_cmd(rv), .write_tab(tab),
      .wdata(wdata), .read_data_a(rda), .read_data_b(rdb), .head_drive(head),
      .transport_ref_clock(refc));
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) cyc_cnt <= cyc_cnt + 1;
   task automatic chk(input logic got, input logic exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s got %b expected %b", $time, msg, got, exp);
      end
   endtask
   // wait n+1 rising edges, ending on a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
      @(posedge clock);
   endtask
   task automatic look();
      @(negedge clock);
   endtask
   task automatic t_decode();
      for (int i = 0; i < 32; i++) begin
         {rec, tw, te, pb, rdl} <= i[4:0];
         cyc(2);
         look();
         chk(wr, rec & (tw | te), "write");
         chk(fw, (rec & (tw | te)) | (pb & rdl), "forward");
         chk(rv, 1'b0, "reverse");
         chk(fa, 1'b0, "fast");
         @(posedge clock);
      end
      {rec, tw, te, pb, rdl} <= 5'h00;
   endtask
   task automatic t_ready();
      logic base, rexp, pexp;
      for (int i = 0; i < 1024; i++) begin
         {cp, rec, tab, ocl, roff, rlp, onl, pb, poff, plp} <= i[9:0];
         cyc(6);
         look();
         base = cp & ~ocl;
         rexp = base & rec & tab & ~roff & (~rlp | onl);
         pexp = base & pb & ~poff & (~plp | onl);
         chk(rr, rexp, "rec ready");
         chk(pr, pexp, "pb ready");
         chk(rlamp, rexp, "rec lamp");
         chk(plamp, pexp, "pb lamp");
         @(posedge clock);
      end
      {cp, rec, tab, ocl, roff, rlp, onl, pb, poff, plp} <= 10'h200;
   endtask
   task automatic t_rewind();
      busy <= 1'b1;
      rew_sw <= 1'b1;
      cyc(10);
      look();
      chk(rwl, 1'b0, "rewind while busy");
      @(posedge clock);
      {busy, door, rew_sw} <= 3'b000;
      cyc(8);
      rew_sw <= 1'b1;
      cyc(10);
      look();
      chk(rwl, 1'b0, "rewind door open");
      @(posedge clock);
      {rew_sw, door} <= 2'b01;
      cyc(8);
      rew_sw <= 1'b1;
      cyc(10);
      look();
      chk(rwl & rv & fa & ~fw, 1'b1, "rewind run");
      @(posedge clock);
      {rew_sw, stp} <= 2'b01;
      cyc(10);
      look();
      chk(rwl | rv | fa, 1'b0, "rewind stop");
      @(posedge clock);
      stp <= 1'b0;
      cyc(8);
      rew_sw <= 1'b1;
      cyc(10);
      rew_sw <= 1'b0;
      endm <= 1'b1;
      cyc(10);
      look();
      chk(le & ~rwl & ~rv, 1'b1, "left end");
      @(posedge clock);
      endm <= 1'b0;
      cyc(8);
      rew_sw <= 1'b1;
      cyc(10);
      look();
      chk(rwl, 1'b0, "rewind at left end");
      @(posedge clock);
      rew_sw <= 1'b0;
   endtask
   task automatic t_ffwd();
      {rec, tab, lff_sw} <= 3'b101;
      cyc(10);
      look();
      chk(ffl, 1'b0, "ff without tab");
      @(posedge clock);
      {rec, lff_sw} <= 2'b00;
      cyc(8);
      lff_sw <= 1'b1;
      cyc(10);
      look();
      chk(ffl & fw & fa & ~rv, 1'b1, "ff run");
      @(posedge clock);
      {lff_sw, endm} <= 2'b01;
      cyc(10);
      look();
      chk(re & ~ffl & ~fa & ~le, 1'b1, "right end");
      @(posedge clock);
      {endm, lff_sw} <= 2'b01;
      cyc(10);
      look();
      chk(ffl, 1'b0, "ff at right end");
      @(posedge clock);
      {lff_sw, rew_sw} <= 2'b01;
      cyc(10);
      {rew_sw, stpx} <= 2'b01;
      cyc(10);
      look();
      chk(re | rwl, 1'b0, "rewind off right, ext stop");
      @(posedge clock);
      stpx <= 1'b0;
   endtask
   task automatic t_load();
      {ocl, rec, tab} <= 3'b111;
      cyc(8);
      lff_sw <= 1'b1;
      cyc(10);
      look();
      chk(ldl & fw & wr & ~fa & ~rr, 1'b1, "load run");
      @(posedge clock);
      {lff_sw, endm, wdata} <= 3'b011;
      cyc(10);
      look();
      chk(re, 1'b0, "no right end in load");
      chk(head & rda & ~rdb, 1'b1, "write echo");
      @(posedge clock);
      {endm, ocl} <= 2'b00;
      cyc(10);
      look();
      chk(lef & ~gpf & ldl, 1'b1, "leader end");
      @(posedge clock);
      bot <= 1'b1;
      cyc(8);
      look();
      chk(gpf, 1'b1, "gap flag");
      repeat (30) begin
         if (ldl === 1'b0)
            break;
         @(negedge clock);
      end
      chk(ldl | lef | gpf | wr, 1'b0, "load done");
      @(posedge clock);
      {bot, rec, tab, wdata} <= 4'h0;
   endtask
   task automatic t_backsp();
      int n_pulse;
      int t0;
      n_pulse = 0;
      pb <= 1'b1;
      cyc(4);
      brev <= 1'b1;
      repeat (5) begin
         @(negedge clock);
         n_pulse += int'(rec_clr === 1'b1);
      end
      chk(n_pulse == 1, 1'b1, "error clear pulse");
      chk(bsl & rv, 1'b1, "block reverse");
      xp_u.play_bits(18);
      t0 = cyc_cnt;
      cyc(15000);
      look();
      chk(bsl, 1'b1, "stopped before gap time");
      repeat (20000) begin
         if (bsl === 1'b0)
            break;
         @(negedge clock);
      end
      chk((cyc_cnt - t0 >= 16406 + 63 * REF_P) && (cyc_cnt - t0 <= 16406 + 65 * REF_P + 30),
          1'b1, "stop distance");
      chk(rv, 1'b0, "reverse dropped");
      @(posedge clock);
      {brev, pb} <= 2'b00;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (96000) @(posedge clock);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      cyc(5);
      look();
      chk(rwl | ldl | ffl | le | re | lef | gpf | bsl, 1'b0, "reset state");
      @(posedge clock);
      t_decode();
      t_ready();
      t_rewind();
      t_ffwd();
      t_load();
      t_backsp();
      conclude();
   end
endmodule
